// *** hdl/spd_pkg.sv ***
package spd_pkg;
  // device type codes (upper nibble of select byte)
  localparam logic [3:0] DEV_TYPE_MEM = 4'hA;
  localparam logic [3:0] DEV_TYPE_CTL = 4'h6;
  // control command selectors: {b3,b2,b1,rw}
  localparam logic [3:0] CMD_SWP0 = 4'h2;
  localparam logic [3:0] CMD_SWP1 = 4'h8;
  localparam logic [3:0] CMD_SWP2 = 4'hA;
  localparam logic [3:0] CMD_SWP3 = 4'h0;
  localparam logic [3:0] CMD_CLEAR_ALL = 4'h6;
  localparam logic [3:0] CMD_RPS0 = 4'h3;
  localparam logic [3:0] CMD_RPS1 = 4'h9;
  localparam logic [3:0] CMD_RPS2 = 4'hB;
  localparam logic [3:0] CMD_RPS3 = 4'h1;
  localparam logic [3:0] CMD_SPA0 = 4'hC;
  localparam logic [3:0] CMD_SPA1 = 4'hE;
  localparam logic [3:0] CMD_PAGE_RD = 4'hD;
  // erased byte value
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // page write buffer depth and index width
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_IDX_W = 4;
  // last data bit index in a byte and ack slot index
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // programming time 5 ms at 10 MHz
  localparam int TW_US = 5000;
  localparam int CLK_MHZ = 10;
  localparam int TW_CYC = TW_US * CLK_MHZ;
  // serial fsm states
  typedef enum logic [2:0] {
    SPD_IDLE = 3'b000,
    SPD_DEVSEL = 3'b001,
    SPD_ADDR = 3'b010,
    SPD_WDATA = 3'b011,
    SPD_RDATA = 3'b100,
    SPD_ACK = 3'b101,
    SPD_RACK = 3'b110
  } spd_state_t;
  // memory access request bundle
  typedef struct packed {
    logic wr;
    logic [8:0] addr;
    logic [7:0] data;
  } spd_mem_req_t;
endpackage : spd_pkg

// *** hdl/spd_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser for pin levels
module spd_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  logic meta_q; // first stage, read only by second
  // two stage capture
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : spd_sync

// *** hdl/spd_prog_timer.sv ***
`timescale 1ns/1ps
// self-timed write cycle counter
module spd_prog_timer #(
  parameter int TW_CYCLES = spd_pkg::TW_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  output logic busy
);
  logic [$clog2(TW_CYCLES+1)-1:0] cnt_q; // remaining cycles
  // load on start, count down to zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= ($clog2(TW_CYCLES+1))'(TW_CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign busy = (cnt_q != '0);
endmodule : spd_prog_timer

// *** hdl/spd_i2c_slave.sv ***
`timescale 1ns/1ps
// Overview of operation
// - slave only, never stretches clock
// - type 1010 memory, 0110 control
// - memory select address must match straps
// - control commands ignore select address
// - eighth select bit is direction
// - ack match; mismatch releases, goes standby
// - start is sda fall, scl high
// - stop is sda rise, scl high
// - read nack then stop gives standby
// - stop after write starts programming
// - receiver pulls sda low on ninth
// - nack writes to protected blocks
// - protect set/clear needs high voltage
// - delivered array reads all ones
// - start resets serial state machine
// - current address read uses counter
// - random read: address, restart, read
// - sequential read while master acks
// - byte or page write up to sixteen
// - page select picks array half
// - page read acks only lower page
// - programming only on stop after ack
module spd_i2c_slave #(
  parameter int TW_CYCLES = spd_pkg::TW_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_addr_in0,
  input wire logic strap_addr_in1,
  input wire logic strap_addr_in2,
  input wire logic high_voltage_detect_level,
  output logic prog_busy,
  output logic page_sel,
  output logic [3:0] block_protect
);
  // reset release through two flops
  logic rst_m_q, rst_s_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  wire rst_i = rst_s_q; // internal active-low reset

  // synchronised pins
  logic scl_s, sda_s, hv_s;
  logic [2:0] strap_sel_s; // logical_serial_addr from straps
  spd_sync #(.RST_VAL(1'b1)) u_scl (.clock(clock), .rst_b(rst_i), .d(scl_in), .q(scl_s));
  spd_sync #(.RST_VAL(1'b1)) u_sda (.clock(clock), .rst_b(rst_i), .d(sda_in), .q(sda_s));
  spd_sync #(.RST_VAL(1'b0)) u_hv (.clock(clock), .rst_b(rst_i), .d(high_voltage_detect_level), .q(hv_s));
  spd_sync #(.RST_VAL(1'b0)) u_a0 (.clock(clock), .rst_b(rst_i), .d(strap_addr_in0), .q(strap_sel_s[0]));
  spd_sync #(.RST_VAL(1'b0)) u_a1 (.clock(clock), .rst_b(rst_i), .d(strap_addr_in1), .q(strap_sel_s[1]));
  spd_sync #(.RST_VAL(1'b0)) u_a2 (.clock(clock), .rst_b(rst_i), .d(strap_addr_in2), .q(strap_sel_s[2]));

  // previous sampled levels for edge detection
  logic scl_p_q, sda_p_q;
  always_ff @(posedge clock or negedge rst_i) begin
    if (!rst_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_p_q; // sample point
  wire scl_fall = ~scl_s & scl_p_q; // drive point
  wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // array, page buffer and protection state
  logic [7:0] mem_q [0:511] = '{default: spd_pkg::ERASED_BYTE}; // delivered erased
  logic [7:0] pbuf_q [0:spd_pkg::PAGE_BYTES-1]; // page write buffer
  logic [spd_pkg::PAGE_IDX_W:0] pcnt_q; // bytes buffered
  logic [8:0] pbase_q; // first address of page write
  logic page_q; // selected half
  logic [3:0] prot_q; // block protection bits
  logic [7:0] addr_q; // address counter within page
  logic [8:0] full_addr; // page plus counter
  assign full_addr = {page_q, addr_q};

  // serial state machine
  spd_pkg::spd_state_t st_q, ret_q;
  logic [3:0] bit_q; // bit index in byte
  logic [7:0] sh_q; // receive shifter
  logic [7:0] tx_q; // transmit shifter
  logic ack_q; // drive low in ack slot
  logic ack_go_q; // ack slot opened by scl fall
  logic is_mem_q; // current transaction is memory
  logic wr_seen_q; // write data byte acked
  logic after_ack_q; // last completed slot was ack
  logic ctl_cmd_q; // pending control write command
  logic [3:0] ctl_sel_q; // pending control selector
  logic sda_drv_q; // registered pull-low
  logic prog_start; // starts write cycle

  // select byte decode
  wire [7:0] rx_byte = {sh_q[6:0], sda_s};
  wire is_mem_sel = rx_byte[7:4] == spd_pkg::DEV_TYPE_MEM;
  wire is_ctl_sel = rx_byte[7:4] == spd_pkg::DEV_TYPE_CTL;
  wire addr_match = rx_byte[3:1] == strap_sel_s;
  wire rw_bit = rx_byte[0];
  wire [3:0] csel = rx_byte[3:0]; // control selector, address ignored
  wire is_swp = (csel == spd_pkg::CMD_SWP0) | (csel == spd_pkg::CMD_SWP1) |
    (csel == spd_pkg::CMD_SWP2) | (csel == spd_pkg::CMD_SWP3) | (csel == spd_pkg::CMD_CLEAR_ALL);
  wire is_spa = (csel == spd_pkg::CMD_SPA0) | (csel == spd_pkg::CMD_SPA1); // page set commands
  wire [1:0] rps_blk = (csel == spd_pkg::CMD_RPS0) ? 2'h0 : (csel == spd_pkg::CMD_RPS1) ? 2'h1 :
    (csel == spd_pkg::CMD_RPS2) ? 2'h2 : 2'h3;
  wire is_rps = (csel == spd_pkg::CMD_RPS0) | (csel == spd_pkg::CMD_RPS1) |
    (csel == spd_pkg::CMD_RPS2) | (csel == spd_pkg::CMD_RPS3);
  wire ctl_ack = is_swp ? hv_s :
    is_rps ? ~prot_q[rps_blk] :
    (csel == spd_pkg::CMD_SPA0) | (csel == spd_pkg::CMD_SPA1) ? 1'b1 :
    (csel == spd_pkg::CMD_PAGE_RD) ? ~page_q : 1'b0;
  wire sel_ack = (is_mem_sel & addr_match) | (is_ctl_sel & ctl_ack);
  wire blk_prot = prot_q[full_addr[8:7]]; // block of current address
  wire last_bit = bit_q == spd_pkg::BIT_LAST;

  // write cycle timer; bus ignored while busy
  spd_prog_timer #(.TW_CYCLES(TW_CYCLES)) u_tmr (.clock(clock), .rst_b(rst_i), .start(prog_start),
    .busy(prog_busy));
  assign prog_start = stop_det & after_ack_q & wr_seen_q & is_mem_q & ~prog_busy;

  // serial fsm: start restarts, stop returns to idle
  always_ff @(posedge clock or negedge rst_i) begin
    if (!rst_i) begin
      st_q <= spd_pkg::SPD_IDLE;
      ret_q <= spd_pkg::SPD_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      tx_q <= spd_pkg::ERASED_BYTE;
      ack_q <= 1'b0;
      ack_go_q <= 1'b0;
      is_mem_q <= 1'b0;
      wr_seen_q <= 1'b0;
      after_ack_q <= 1'b0;
      ctl_cmd_q <= 1'b0;
      ctl_sel_q <= '0;
      addr_q <= '0;
      pcnt_q <= '0;
      pbase_q <= '0;
      page_q <= 1'b0;
      prot_q <= '0;
    end else if (prog_busy) begin
      st_q <= spd_pkg::SPD_IDLE; // bus ignored in write cycle
    end else if (start_det) begin
      st_q <= spd_pkg::SPD_DEVSEL;
      bit_q <= '0;
      ack_q <= 1'b0;
      ack_go_q <= 1'b0;
      after_ack_q <= 1'b0;
      ctl_cmd_q <= 1'b0;
    end else if (stop_det) begin
      // control writes take effect on stop after ack
      if (ctl_cmd_q && after_ack_q) begin
        if (ctl_sel_q == spd_pkg::CMD_CLEAR_ALL) prot_q <= '0;
        else if (ctl_sel_q == spd_pkg::CMD_SPA0) page_q <= 1'b0;
        else if (ctl_sel_q == spd_pkg::CMD_SPA1) page_q <= 1'b1;
        else if (ctl_sel_q == spd_pkg::CMD_SWP0) prot_q[0] <= 1'b1;
        else if (ctl_sel_q == spd_pkg::CMD_SWP1) prot_q[1] <= 1'b1;
        else if (ctl_sel_q == spd_pkg::CMD_SWP2) prot_q[2] <= 1'b1;
        else if (ctl_sel_q == spd_pkg::CMD_SWP3) prot_q[3] <= 1'b1;
      end
      st_q <= spd_pkg::SPD_IDLE;
      ack_q <= 1'b0;
      ack_go_q <= 1'b0;
      wr_seen_q <= 1'b0;
      ctl_cmd_q <= 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        spd_pkg::SPD_DEVSEL, spd_pkg::SPD_ADDR, spd_pkg::SPD_WDATA: begin
          sh_q <= rx_byte; // msb first
          bit_q <= bit_q + 4'h1;
          // first pulse after ack is the stop slot, keep the flag
          if (bit_q != '0) after_ack_q <= 1'b0;
        end
        spd_pkg::SPD_RDATA: begin
          bit_q <= bit_q + 4'h1;
          after_ack_q <= 1'b0;
        end
        spd_pkg::SPD_ACK: begin
          after_ack_q <= 1'b1; // ninth slot sampled
        end
        spd_pkg::SPD_RACK: begin
          // master ack continues, nack waits for stop
          if (sda_s) begin
            st_q <= spd_pkg::SPD_IDLE;
          end else begin
            st_q <= spd_pkg::SPD_RDATA; // next byte loads on scl fall
            bit_q <= '0;
          end
        end
        default: st_q <= spd_pkg::SPD_IDLE;
      endcase
      // byte complete: decide the ack slot
      if (last_bit && st_q == spd_pkg::SPD_DEVSEL) begin
        ack_q <= sel_ack;
        is_mem_q <= is_mem_sel;
        if (is_mem_sel & addr_match) begin
          ret_q <= rw_bit ? spd_pkg::SPD_RDATA : spd_pkg::SPD_ADDR;
          st_q <= spd_pkg::SPD_ACK;
        end else if (is_ctl_sel & ctl_ack) begin
          ctl_cmd_q <= is_swp | is_spa; // applied on stop
          ctl_sel_q <= csel;
          ret_q <= spd_pkg::SPD_IDLE;
          st_q <= spd_pkg::SPD_ACK;
        end else begin
          st_q <= spd_pkg::SPD_IDLE; // release and standby
        end
      end else if (last_bit && st_q == spd_pkg::SPD_ADDR) begin
        addr_q <= rx_byte;
        pbase_q <= {page_q, rx_byte};
        pcnt_q <= '0;
        ack_q <= 1'b1;
        ret_q <= spd_pkg::SPD_WDATA;
        st_q <= spd_pkg::SPD_ACK;
      end else if (last_bit && st_q == spd_pkg::SPD_WDATA) begin
        ack_q <= ~blk_prot;
        if (!blk_prot) begin
          // buffer byte; after sixteen the count holds and slot zero is overwritten
          pbuf_q[pcnt_q[spd_pkg::PAGE_IDX_W-1:0]] <= rx_byte;
          if (pcnt_q != (spd_pkg::PAGE_IDX_W+1)'(spd_pkg::PAGE_BYTES)) pcnt_q <= pcnt_q + 1'b1;
          addr_q <= addr_q + 8'h01;
          wr_seen_q <= 1'b1;
        end
        ret_q <= spd_pkg::SPD_WDATA;
        st_q <= spd_pkg::SPD_ACK;
      end else if (last_bit && st_q == spd_pkg::SPD_RDATA) begin
        addr_q <= addr_q + 8'h01;
        st_q <= spd_pkg::SPD_RACK;
      end
    end else if (scl_fall) begin
      // leave ack slot on its falling edge
      if (st_q == spd_pkg::SPD_ACK && after_ack_q) begin
        ack_q <= 1'b0;
        ack_go_q <= 1'b0;
        bit_q <= '0;
        st_q <= ret_q;
        if (ret_q == spd_pkg::SPD_RDATA) tx_q <= mem_q[full_addr];
      end else if (st_q == spd_pkg::SPD_ACK) begin
        ack_go_q <= 1'b1; // pull only once scl is low
      end else if (st_q == spd_pkg::SPD_RACK) begin
        tx_q <= spd_pkg::ERASED_BYTE; // release for master ack slot
      end else if (st_q == spd_pkg::SPD_RDATA && bit_q == '0) begin
        tx_q <= mem_q[full_addr]; // next byte of sequential read
      end else if (st_q == spd_pkg::SPD_RDATA) begin
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  // commit buffered page on programming start
  always_ff @(posedge clock) begin
    if (prog_start) begin
      for (int i = 0; i < spd_pkg::PAGE_BYTES; i++) begin
        if (i < int'(pcnt_q)) mem_q[{pbase_q[8:4], pbase_q[3:0] + 4'(i)}] <= pbuf_q[i];
      end
    end
  end

  // sda pull-low: ack slot or zero data bit, open drain only
  // sda only moves while scl low, so no false start or stop
  wire pull_ack = (st_q == spd_pkg::SPD_ACK) & ack_q & ack_go_q;
  wire pull_dat = ((st_q == spd_pkg::SPD_RDATA) | (st_q == spd_pkg::SPD_RACK)) & ~tx_q[7];
  always_ff @(posedge clock or negedge rst_i) begin
    if (!rst_i) sda_drv_q <= 1'b0;
    else sda_drv_q <= (pull_ack | pull_dat) & ~start_det & ~stop_det;
  end
  assign sda_out = 1'b0;
  assign sda_oe = sda_drv_q; // scl is input only, no stretching
  assign page_sel = page_q;
  assign block_protect = prot_q;
endmodule : spd_i2c_slave

// *** verif/spd_i2c_slave_monitor.sv ***
`timescale 1ns/1ps
// pin-level checker for the serial slave
module spd_i2c_slave_chk #(
  parameter int TW_CYCLES = 50
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic strap_addr_in0,
  input wire logic strap_addr_in1,
  input wire logic strap_addr_in2,
  input wire logic high_voltage_detect_level,
  input wire logic prog_busy,
  input wire logic page_sel,
  input wire logic [3:0] block_protect
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic [15:0] busy_cnt_q; // length of the running write cycle
  // count busy cycles, clear when idle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= prog_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  open_drain_a: assert property (sda_out == 1'b0) else $error("sda driven high");
  ack_release_a: assert property ($fell(sda_oe) |-> !scl_in) else $error("sda released with scl high");
  drive_bounded_a: assert property ($rose(sda_oe) |-> ##[1:400] !sda_oe) else $error("sda held too long");
  busy_silent_a: assert property (prog_busy |-> !sda_oe) else $error("answer while busy");
  busy_len_a: assert property ($fell(prog_busy) |-> busy_cnt_q >= TW_CYCLES - 2 && busy_cnt_q <= TW_CYCLES + 2)
    else $error("write cycle length wrong");
  busy_on_stop_a: assert property ($rose(prog_busy) |-> scl_in && sda_in) else $error("write not on stop");
  page_on_stop_a: assert property ($changed(page_sel) |-> scl_in && sda_in) else $error("page not on stop");
  protect_hv_a: assert property ($changed(block_protect) |-> high_voltage_detect_level && scl_in)
    else $error("protect change without high voltage");
  cover property ($rose(prog_busy));
  cover property ($fell(sda_oe));
  cover property ($rose(page_sel));
endmodule : spd_i2c_slave_chk
bind spd_i2c_slave spd_i2c_slave_chk #(.TW_CYCLES(TW_CYCLES)) spd_i2c_slave_chk_i (.clock, .rst_b, .scl_in,
  .sda_in, .sda_out, .sda_oe, .strap_addr_in0, .strap_addr_in1, .strap_addr_in2, .high_voltage_detect_level,
  .prog_busy, .page_sel, .block_protect);

// *** verif/spd_bfm.sv ***
`timescale 1ns/1ps
// bus master model, sda open drain with pull-up
module spd_bfm (
  input wire logic clock,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic scl_q = 1'b1; // scl level
  logic drv_q = 1'b1; // low pulls sda
  assign scl = scl_q;
  assign sda = drv_q & ~sda_oe; // wired-and
  // n falling clock edges
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask : w
  // start or repeated start
  task automatic start();
    w(3);
    drv_q = 1'b1;
    w(10);
    scl_q = 1'b1;
    w(10);
    drv_q = 1'b0;
    w(10);
    scl_q = 1'b0;
  endtask : start
  // stop, sda rises with scl high
  task automatic stop();
    w(3);
    drv_q = 1'b0;
    w(10);
    scl_q = 1'b1;
    w(10);
    drv_q = 1'b1;
    w(10);
  endtask : stop
  // one bit, changed only while scl low
  task automatic bit_io(input logic b, output logic s);
    w(3);
    drv_q = b;
    w(10);
    scl_q = 1'b1;
    w(10);
    s = sda;
    scl_q = 1'b0;
  endtask : bit_io
  // msb first ninth slot ma, 1 releases
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] r, output logic s);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(ma, s);
  endtask : xfer
endmodule : spd_bfm

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
// self-checking bench for the serial slave
module tb_top;
  localparam int TW = 400; // shortened write cycle
  localparam logic [7:0] SEL = {spd_pkg::DEV_TYPE_MEM, 3'h5, 1'b0}; // matches straps
  localparam logic [3:0] CTL = spd_pkg::DEV_TYPE_CTL;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic scl_in;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic high_voltage_detect_level = 1'b0;
  logic prog_busy;
  logic page_sel;
  logic [3:0] block_protect;
  int errors = 0;
  int n_compared = 0;
  initial forever #50 clock = ~clock;
  spd_i2c_slave #(.TW_CYCLES(TW)) spd_i2c_slave_i (.clock, .rst_b, .scl_in, .sda_in, .sda_out, .sda_oe,
    .strap_addr_in0(1'b1), .strap_addr_in1(1'b0), .strap_addr_in2(1'b1), .high_voltage_detect_level,
    .prog_busy, .page_sel, .block_protect);
  spd_bfm spd_bfm_i (.clock, .sda_oe, .scl(scl_in), .sda(sda_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // write a byte, a is 1 when acknowledged
  task automatic wr(input logic [7:0] d, output logic [7:0] a);
    logic [7:0] r;
    logic s;
    spd_bfm_i.xfer(d, 1'b1, r, s);
    a = {7'h00, ~s};
  endtask : wr
  // read a byte, no acknowledge on the last
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    spd_bfm_i.xfer(8'hFF, last, d, s);
  endtask : rd
  // bounded wait for the write cycle
  task automatic idle();
    int n;
    n = 0;
    while (prog_busy !== 1'b0) begin
      n++;
      @(negedge clock);
      if (n > 2 * TW) begin
        errors++;
        close_out();
      end
    end
  endtask : idle
  // lone select byte then stop
  task automatic cmd(input logic [7:0] sel, input logic [7:0] exp);
    logic [7:0] a;
    spd_bfm_i.start();
    wr(sel, a);
    chk(a, exp);
    spd_bfm_i.stop();
    idle();
  endtask : cmd
  // address then restart for reading
  task automatic seek(input logic [7:0] adr);
    logic [7:0] a;
    spd_bfm_i.start();
    wr(SEL, a);
    wr(adr, a);
    spd_bfm_i.start();
    wr(SEL | 8'h01, a);
    chk(a, 8'h01);
  endtask : seek
  // wrong straps, wrong type, no start
  task automatic t_select();
    logic [7:0] a;
    cmd({spd_pkg::DEV_TYPE_MEM, 3'h2, 1'b0}, 8'h00);
    cmd({4'h5, 3'h5, 1'b0}, 8'h00);
    spd_bfm_i.start();
    wr({spd_pkg::DEV_TYPE_MEM, 3'h3, 1'b1}, a);
    wr(SEL, a);
    chk(a, 8'h00);
    spd_bfm_i.stop();
  endtask : t_select
  // page write, refusal while busy, reads
  task automatic t_data();
    logic [7:0] a;
    logic [7:0] d;
    spd_bfm_i.start();
    wr(SEL, a);
    chk(a, 8'h01);
    wr(8'h20, a);
    wr(8'h5A, a);
    wr(8'hC3, a);
    chk(a, 8'h01);
    spd_bfm_i.stop();
    chk({7'h00, prog_busy}, 8'h01);
    cmd(SEL, 8'h00);
    seek(8'h20);
    rd(1'b1, d);
    chk(d, 8'h5A);
    spd_bfm_i.stop();
    chk({7'h00, prog_busy}, 8'h00);
    cmd(SEL | 8'h01, 8'h01);
    spd_bfm_i.start();
    wr(SEL | 8'h01, a);
    rd(1'b0, d);
    chk(d, 8'hC3);
    rd(1'b1, d);
    chk(d, 8'hFF);
    spd_bfm_i.stop();
  endtask : t_data
  // stop in mid-byte programs nothing
  task automatic t_abort();
    logic [7:0] a;
    logic s;
    spd_bfm_i.start();
    wr(SEL, a);
    wr(8'h40, a);
    repeat (4) spd_bfm_i.bit_io(1'b0, s);
    spd_bfm_i.stop();
    chk({7'h00, prog_busy}, 8'h00);
  endtask : t_abort
  // upper page and back
  task automatic t_page();
    logic [7:0] d;
    cmd({CTL, spd_pkg::CMD_SPA1}, 8'h01);
    chk({7'h00, page_sel}, 8'h01);
    cmd({CTL, spd_pkg::CMD_PAGE_RD}, 8'h00);
    seek(8'h20);
    rd(1'b1, d);
    chk(d, 8'hFF);
    spd_bfm_i.stop();
    cmd({CTL, spd_pkg::CMD_SPA0}, 8'h01);
    cmd({CTL, spd_pkg::CMD_PAGE_RD}, 8'h01);
  endtask : t_page
  // protection set, write refused, clear
  task automatic t_protect();
    logic [7:0] a;
    cmd({CTL, spd_pkg::CMD_SWP0}, 8'h00);
    high_voltage_detect_level = 1'b1;
    cmd({CTL, spd_pkg::CMD_SWP0}, 8'h01);
    chk({4'h0, block_protect}, 8'h01);
    high_voltage_detect_level = 1'b0;
    cmd({CTL, spd_pkg::CMD_RPS0}, 8'h00);
    spd_bfm_i.start();
    wr(SEL, a);
    wr(8'h05, a);
    wr(8'h11, a);
    chk(a, 8'h00);
    spd_bfm_i.stop();
    idle();
    high_voltage_detect_level = 1'b1;
    cmd({CTL, spd_pkg::CMD_CLEAR_ALL}, 8'h01);
    chk({4'h0, block_protect}, 8'h00);
    high_voltage_detect_level = 1'b0;
  endtask : t_protect
  // reset, then scenarios in turn
  initial begin
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    repeat (10) @(negedge clock); // no command before init delay
    chk({1'b0, page_sel, block_protect, prog_busy, sda_oe}, 8'h00);
    t_select();
    t_data();
    t_abort();
    t_page();
    t_protect();
    close_out();
  end
endmodule : tb_top
